//--- ncps_pkg.sv
/*
  Shared constants for the cached page program host controller: register map,
  control and status bit positions, NAND command bytes, pin timing and state codes.
  Assumes a 125 MHz hclk and one NAND die on the strobed bus.
*/
package ncps_pkg;

  // ==========================================================
  // Register map (byte offsets on AHB-Lite)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COL = 8'h04;
  localparam logic [7:0] REG_ROW_A = 8'h08;
  localparam logic [7:0] REG_ROW_B = 8'h0c;
  localparam logic [7:0] REG_DATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // ==========================================================
  // Control register bits (write, self clearing)
  localparam int CTRL_FIRST = 0;
  localparam int CTRL_SECOND = 1;
  localparam int CTRL_CACHE = 2;
  localparam int CTRL_LAST = 3;
  localparam int CTRL_STATUS = 4;
  localparam int CTRL_MULTI = 5;
  localparam int CTRL_ERR_CLR = 7;

  // ==========================================================
  // Status register fields
  localparam int ST_BUSY = 8;
  localparam int ST_ERR = 9;
  localparam int ST_ACTIVE = 10;
  localparam int ST_MULTI = 11;
  localparam int ST_RB = 12;
  localparam int ST_CUR_VALID = 13;
  localparam int ST_PREV_VALID = 14;
  localparam int ST_SECOND = 15;
  localparam int ST_PAGES_LSB = 16;

  // Status byte bits from the die
  localparam int SB_PB_READY = 5;
  localparam int SB_DC_READY = 6;

  // ==========================================================
  // Address layout
  localparam int COL_W = 16;
  localparam int ROW_W = 17;
  localparam int PAGE_W = 6;
  localparam int BLOCK_W = 11;
  localparam int DISTRICT_BIT = 6;
  localparam logic [2:0] ADDR_LAST_IDX = 3'd4;
  localparam logic [5:0] LAST_PAGE_IDX = 6'd63;

  // ==========================================================
  // Command bytes
  localparam logic [7:0] CMD_DATA_IN = 8'h80;
  localparam logic [7:0] CMD_DATA_IN_2ND = 8'h81;
  localparam logic [7:0] CMD_PLANE_GAP = 8'h11;
  localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
  localparam logic [7:0] CMD_PROG = 8'h10;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;

  // ==========================================================
  // Pin timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STROBE_NS = 25;
  localparam int HOLD_NS = 15;
  localparam int WB_NS = 100;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] WB_CYC = 4'((WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] SYNC_CYC = 4'd2;
  localparam int SYNC_W = 9;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    CYK_CMD = 2'd0,
    CYK_ADDR = 2'd1,
    CYK_DWR = 2'd2,
    CYK_RD = 2'd3
  } ncps_cyc_kind_t;

  typedef enum logic [3:0] {
    CY_IDLE = 4'b0001,
    CY_SETUP = 4'b0010,
    CY_LOW = 4'b0100,
    CY_HOLD = 4'b1000
  } ncps_cyc_state_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_CMD = 6'b000010,
    S_ADDR = 6'b000100,
    S_LOAD = 6'b001000,
    S_WAITB = 6'b010000,
    S_SRD = 6'b100000
  } ncps_state_t;

endpackage : ncps_pkg

//--- ncps_sync.sv
/*
  Two flip-flop synchroniser for the NAND data inputs and the ready/busy pin.
  Assumes the inputs are asynchronous to hclk; only the second stage is read.
*/
`timescale 1ns/10ps
`default_nettype none
module ncps_sync (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins in, synchronised out
  input wire logic [ncps_pkg::SYNC_W-1:0] async_in,
  output logic [ncps_pkg::SYNC_W-1:0] sync_out
);

  logic [ncps_pkg::SYNC_W-1:0] stage1_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1_reg <= '0;
      sync_out <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end

endmodule : ncps_sync
`default_nettype wire

//--- ncps_pin_cycle.sv
/*
  One strobed bus cycle: command, address or data write on we_n, or data read on re_n.
  Assumes start is a one-cycle pulse given only while idle, and rd_data is already synchronised.
*/
`timescale 1ns/10ps
`default_nettype none
module ncps_pin_cycle (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request
  input wire logic start,
  input wire ncps_pkg::ncps_cyc_kind_t kind,
  input wire logic [7:0] wbyte,
  output logic done,
  output logic [7:0] rbyte,
  // Synchronised data pins
  input wire logic [7:0] rd_data,
  // Strobed bus pins
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe_n
);

  ncps_pkg::ncps_cyc_state_t state_reg;
  logic [3:0] cnt_reg;
  logic rd_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ncps_pkg::CY_IDLE;
      cnt_reg <= 4'h0;
      rd_reg <= 1'b0;
      done <= 1'b0;
      rbyte <= 8'h00;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 8'h00;
      io_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_reg)
        ncps_pkg::CY_IDLE: begin
          if (start) begin
            rd_reg <= (kind == ncps_pkg::CYK_RD);
            io_out <= wbyte;
            cle <= (kind == ncps_pkg::CYK_CMD);
            ale <= (kind == ncps_pkg::CYK_ADDR);
            io_oe_n <= (kind == ncps_pkg::CYK_RD);
            state_reg <= ncps_pkg::CY_SETUP;
          end
        end
        ncps_pkg::CY_SETUP: begin
          // Read strobe stretched to cover the input synchroniser delay
          we_n <= rd_reg;
          re_n <= ~rd_reg;
          cnt_reg <= rd_reg ? (ncps_pkg::STROBE_CYC + ncps_pkg::SYNC_CYC - 4'h1) : (ncps_pkg::STROBE_CYC - 4'h1);
          state_reg <= ncps_pkg::CY_LOW;
        end
        ncps_pkg::CY_LOW: begin
          if (cnt_reg == 4'h0) begin
            we_n <= 1'b1;
            re_n <= 1'b1;
            if (rd_reg) begin
              rbyte <= rd_data;
            end
            cnt_reg <= ncps_pkg::HOLD_CYC - 4'h1;
            state_reg <= ncps_pkg::CY_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        ncps_pkg::CY_HOLD: begin
          if (cnt_reg == 4'h0) begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe_n <= 1'b1;
            done <= 1'b1;
            state_reg <= ncps_pkg::CY_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= ncps_pkg::CY_IDLE;
        end
      endcase
    end
  end

endmodule : ncps_pin_cycle
`default_nettype wire

//--- ncps_host.sv
/*
  Host controller for cached page programming on a NAND die: single plane 15h/10h,
  two-district 80h/11h/81h cached programming and the 70h/71h status reads.
  Software reaches it over AHB-Lite; the die is driven on its strobed pins.
  Assumes one die with its own ready/busy pin and a 125 MHz hclk.
*/
`timescale 1ns/10ps
`default_nettype none
module ncps_host (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // NAND strobed bus
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe_n,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_pin
);

  // ==========================================================
  // Declarations
  ncps_pkg::ncps_state_t st_reg;
  ncps_pkg::ncps_state_t st_next;
  logic dp_wr_reg;
  logic [7:0] dp_addr_reg;
  logic [ncps_pkg::COL_W-1:0] col_reg;
  logic [ncps_pkg::ROW_W-1:0] row_a_reg;
  logic [ncps_pkg::ROW_W-1:0] row_b_reg;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_next;
  logic [2:0] addr_idx_reg;
  logic [3:0] wait_reg;
  logic [5:0] pages_reg;
  logic [ncps_pkg::BLOCK_W-1:0] block_reg;
  logic multi_reg;
  logic active_reg;
  logic second_reg;
  logic use_b_reg;
  logic issued_reg;
  logic err_reg;
  logic [7:0] status_reg;
  logic ce_n_reg;
  logic [ncps_pkg::SYNC_W-1:0] pins_sync;
  logic cyc_done;
  logic [7:0] cyc_rbyte;
  ncps_pkg::ncps_cyc_kind_t cyc_kind;
  logic [7:0] cyc_wbyte;

  // ==========================================================
  // Input synchroniser and cycle engine
  ncps_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({ready_busy_pin, io_in}),
    .sync_out(pins_sync)
  );

  wire rb_ready = pins_sync[8];
  wire st_idle = (st_reg == ncps_pkg::S_IDLE);
  wire st_load = (st_reg == ncps_pkg::S_LOAD);
  wire st_cmd = (st_reg == ncps_pkg::S_CMD);
  wire st_addr = (st_reg == ncps_pkg::S_ADDR);
  wire st_srd = (st_reg == ncps_pkg::S_SRD);
  wire st_waitb = (st_reg == ncps_pkg::S_WAITB);

  // ==========================================================
  // AHB-Lite address and data phase decode
  wire ap_take = hsel & hready & htrans[1];
  wire dp_ctrl = dp_wr_reg & (dp_addr_reg == ncps_pkg::REG_CTRL);
  wire dp_data = dp_wr_reg & (dp_addr_reg == ncps_pkg::REG_DATA);
  wire data_wait = dp_data & st_load;
  // Data writes in S_LOAD stall the bus until the byte's pin cycle is done: no buffer needed
  assign hreadyout = ~data_wait | cyc_done;
  assign hresp = 1'b0;
  wire reg_wr_ok = st_idle | st_load;
  wire wr_col = dp_wr_reg & (dp_addr_reg == ncps_pkg::REG_COL) & reg_wr_ok;
  wire wr_row_a = dp_wr_reg & (dp_addr_reg == ncps_pkg::REG_ROW_A) & reg_wr_ok;
  wire wr_row_b = dp_wr_reg & (dp_addr_reg == ncps_pkg::REG_ROW_B) & reg_wr_ok;
  wire wr_addr_late = dp_wr_reg & ~reg_wr_ok & ((dp_addr_reg == ncps_pkg::REG_COL) |
                      (dp_addr_reg == ncps_pkg::REG_ROW_A) | (dp_addr_reg == ncps_pkg::REG_ROW_B));

  // ==========================================================
  // Order acceptance checks
  wire op_first = dp_ctrl & hwdata[ncps_pkg::CTRL_FIRST];
  wire op_second = dp_ctrl & hwdata[ncps_pkg::CTRL_SECOND];
  wire op_cache = dp_ctrl & hwdata[ncps_pkg::CTRL_CACHE];
  wire op_last = dp_ctrl & hwdata[ncps_pkg::CTRL_LAST];
  wire op_status = dp_ctrl & hwdata[ncps_pkg::CTRL_STATUS];
  wire [ncps_pkg::BLOCK_W-1:0] blk_a = row_a_reg[ncps_pkg::ROW_W-1:ncps_pkg::PAGE_W];
  wire same_block = ~active_reg | (blk_a == block_reg);
  wire other_district = row_a_reg[ncps_pkg::DISTRICT_BIT] != row_b_reg[ncps_pkg::DISTRICT_BIT];
  wire same_page = row_a_reg[ncps_pkg::PAGE_W-1:0] == row_b_reg[ncps_pkg::PAGE_W-1:0];
  wire pair_done = ~multi_reg | second_reg;
  wire room_left = ~multi_reg | (pages_reg != ncps_pkg::LAST_PAGE_IDX);
  wire acc_last = op_last & st_load & pair_done;
  wire acc_cache = ~op_last & op_cache & st_load & pair_done & room_left;
  wire acc_second = ~op_last & ~op_cache & op_second & st_load & multi_reg & ~second_reg &
                    other_district & same_page;
  wire acc_first = ~op_last & ~op_cache & ~op_second & op_first & st_idle & same_block;
  wire acc_status = ~op_last & ~op_cache & ~op_second & ~op_first & op_status & st_idle;
  wire any_op = op_first | op_second | op_cache | op_last | op_status;
  wire any_acc = acc_first | acc_second | acc_cache | acc_last | acc_status;
  wire refuse = (dp_ctrl & any_op & ~any_acc) | (dp_data & ~st_load) | wr_addr_late;
  wire [7:0] stat_cmd = multi_reg ? ncps_pkg::CMD_STATUS_MULTI : ncps_pkg::CMD_STATUS;

  // ==========================================================
  // Cycle engine request
  wire [ncps_pkg::ROW_W-1:0] row_sel = use_b_reg ? row_b_reg : row_a_reg;
  wire [39:0] addr_all = {7'h00, row_sel, col_reg};
  wire [7:0] addr_byte = addr_all[{addr_idx_reg, 3'b000} +: 8];
  wire need_cycle = st_cmd | st_addr | st_srd | data_wait;
  wire cyc_start = need_cycle & ~issued_reg;
  assign cyc_kind = st_load ? ncps_pkg::CYK_DWR : st_addr ? ncps_pkg::CYK_ADDR :
                    st_srd ? ncps_pkg::CYK_RD : ncps_pkg::CYK_CMD;
  // Data cycles overlap programming of the previous page
  assign cyc_wbyte = st_load ? hwdata[7:0] : st_addr ? addr_byte : cmd_reg;

  ncps_pin_cycle u_cycle (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(cyc_start),
    .kind(cyc_kind),
    .wbyte(cyc_wbyte),
    .done(cyc_done),
    .rbyte(cyc_rbyte),
    .rd_data(pins_sync[7:0]),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .re_n(re_n),
    .io_out(io_out),
    .io_oe_n(io_oe_n)
  );

  // ==========================================================
  // Sequencer next state
  wire cmd_goes_addr = (cmd_reg == ncps_pkg::CMD_DATA_IN) | (cmd_reg == ncps_pkg::CMD_DATA_IN_2ND);
  wire cmd_goes_wait = (cmd_reg == ncps_pkg::CMD_PLANE_GAP) | (cmd_reg == ncps_pkg::CMD_CACHE_PROG) |
                       (cmd_reg == ncps_pkg::CMD_PROG);
  wire wait_over = st_waitb & (wait_reg == 4'h0) & rb_ready;

  always_comb begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    case (st_reg)
      ncps_pkg::S_IDLE: begin
        if (acc_first) begin
          st_next = ncps_pkg::S_CMD;
          cmd_next = ncps_pkg::CMD_DATA_IN;
        end else if (acc_status) begin
          st_next = ncps_pkg::S_CMD;
          cmd_next = stat_cmd;
        end
      end
      ncps_pkg::S_LOAD: begin
        if (acc_last) begin
          st_next = ncps_pkg::S_CMD;
          cmd_next = ncps_pkg::CMD_PROG;
        end else if (acc_cache) begin
          st_next = ncps_pkg::S_CMD;
          cmd_next = ncps_pkg::CMD_CACHE_PROG;
        end else if (acc_second) begin
          st_next = ncps_pkg::S_CMD;
          cmd_next = ncps_pkg::CMD_PLANE_GAP;
        end
      end
      ncps_pkg::S_CMD: begin
        if (cyc_done) begin
          st_next = cmd_goes_addr ? ncps_pkg::S_ADDR : cmd_goes_wait ? ncps_pkg::S_WAITB : ncps_pkg::S_SRD;
        end
      end
      ncps_pkg::S_ADDR: begin
        if (cyc_done && addr_idx_reg == ncps_pkg::ADDR_LAST_IDX) begin
          st_next = ncps_pkg::S_LOAD;
        end
      end
      ncps_pkg::S_WAITB: begin
        // Busy length varies with cache state and final page; only the pin tells
        if (wait_over) begin
          st_next = ncps_pkg::S_CMD;
          // Straight from 11h to 81h with nothing else between
          cmd_next = (cmd_reg == ncps_pkg::CMD_PLANE_GAP) ? ncps_pkg::CMD_DATA_IN_2ND : stat_cmd;
        end
      end
      ncps_pkg::S_SRD: begin
        if (cyc_done) begin
          st_next = ncps_pkg::S_IDLE;
        end
      end
      default: begin
        st_next = ncps_pkg::S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Sequencer state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= ncps_pkg::S_IDLE;
      cmd_reg <= 8'h00;
      ce_n_reg <= 1'b1;
      issued_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      ce_n_reg <= (st_next == ncps_pkg::S_IDLE);
      issued_reg <= cyc_start | (issued_reg & ~cyc_done);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_idx_reg <= 3'd0;
      wait_reg <= 4'h0;
    end else begin
      if (st_cmd && cyc_done) begin
        addr_idx_reg <= 3'd0;
        wait_reg <= ncps_pkg::WB_CYC - 4'h1;
      end else if (st_addr && cyc_done) begin
        addr_idx_reg <= addr_idx_reg + 3'd1;
      end else if (st_waitb && wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end

  // ==========================================================
  // Sequence tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      multi_reg <= 1'b0;
      active_reg <= 1'b0;
      second_reg <= 1'b0;
      use_b_reg <= 1'b0;
      pages_reg <= 6'd0;
      block_reg <= '0;
    end else begin
      if (acc_first) begin
        multi_reg <= active_reg ? multi_reg : hwdata[ncps_pkg::CTRL_MULTI];
        active_reg <= 1'b1;
        block_reg <= blk_a;
        second_reg <= 1'b0;
        use_b_reg <= 1'b0;
      end else if (acc_second) begin
        second_reg <= 1'b1;
        use_b_reg <= 1'b1;
      end else if (acc_cache) begin
        pages_reg <= pages_reg + 6'd1;
      end else if (acc_last) begin
        active_reg <= 1'b0;
        pages_reg <= 6'd0;
      end
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      col_reg <= '0;
      row_a_reg <= '0;
      row_b_reg <= '0;
    end else begin
      if (wr_col) begin
        col_reg <= hwdata[ncps_pkg::COL_W-1:0];
      end
      if (wr_row_a) begin
        row_a_reg <= hwdata[ncps_pkg::ROW_W-1:0];
      end
      if (wr_row_b) begin
        row_b_reg <= hwdata[ncps_pkg::ROW_W-1:0];
      end
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= refuse | (err_reg & ~(dp_ctrl & hwdata[ncps_pkg::CTRL_ERR_CLR]));
    end
  end

  // Status byte captured as read; its meaning depends on 70h or 71h
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= 8'h00;
    end else if (st_srd && cyc_done) begin
      status_reg <= cyc_rbyte;
    end
  end

  // ==========================================================
  // Read path and bus phase registers
  wire cur_valid = status_reg[ncps_pkg::SB_PB_READY];
  wire prev_valid = status_reg[ncps_pkg::SB_DC_READY];
  wire [31:0] status_word = {10'h000, pages_reg, second_reg, prev_valid, cur_valid, rb_ready,
                             multi_reg, active_reg, err_reg, ~(st_idle | st_load), status_reg};
  wire [7:0] rd_off = haddr[7:0];
  wire [31:0] rd_mux = (rd_off == ncps_pkg::REG_COL) ? {16'h0000, col_reg} :
                       (rd_off == ncps_pkg::REG_ROW_A) ? {15'h0000, row_a_reg} :
                       (rd_off == ncps_pkg::REG_ROW_B) ? {15'h0000, row_b_reg} :
                       (rd_off == ncps_pkg::REG_STATUS) ? status_word : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      dp_wr_reg <= ap_take & hwrite;
      dp_addr_reg <= haddr[7:0];
      if (ap_take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  assign ce_n = ce_n_reg;
  assign wp_n = 1'b1;

endmodule : ncps_host
`default_nettype wire

//--- ncps_host_properties.sv
/*
  Pin checker for the cached program host.
  Assumes a bind to ncps_host and one hclk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ncps_host_properties (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Strobed bus
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe_n,
  input wire logic ready_busy_pin
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // Helpers
  logic we_reg;
  logic gap_reg;
  wire strobe_end = cle && we_n && !we_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      we_reg <= 1'h1;
      gap_reg <= 1'h0;
    end else begin
      we_reg <= we_n;
      if (strobe_end) gap_reg <= (io_out == 8'h11);
    end
  end
  // ==========
  // Properties
  property p_gap15; strobe_end && io_out == 8'h15 |=> we_n [*8]; endproperty
  property p_gap10; strobe_end && io_out == 8'h10 |=> (we_n && re_n) [*8]; endproperty
  property p_busy; !ready_busy_pin [*4] |-> we_n && re_n; endproperty
  property p_stat; strobe_end && io_out == 8'h10 |-> ##[14:400] cle && io_out[7:1] == 7'h38; endproperty
  property p_gap; gap_reg && cle && !we_n |-> io_out == 8'h81 || io_out == 8'h70; endproperty
  property p_excl; !(cle && ale); endproperty
  property p_wp; wp_n; endproperty
  property p_drive; !we_n |-> !io_oe_n; endproperty
  property p_quiet; ce_n |-> we_n && re_n; endproperty
  a_gap15: assert property (p_gap15) else $error("strobe soon after cache command");
  a_gap10: assert property (p_gap10) else $error("strobe soon after final command");
  a_busy: assert property (p_busy) else $error("strobe while die busy");
  a_stat: assert property (p_stat) else $error("no status read after final command");
  a_gap: assert property (p_gap) else $error("wrong command after plane gap");
  a_excl: assert property (p_excl) else $error("command and address latch together");
  a_wp: assert property (p_wp) else $error("write protect asserted");
  a_drive: assert property (p_drive) else $error("write strobe without driving io");
  a_quiet: assert property (p_quiet) else $error("strobe while deselected");
  c_cache: cover property (strobe_end && io_out == 8'h15);
  c_last: cover property (strobe_end && io_out == 8'h10);
  c_multi: cover property (strobe_end && io_out == 8'h71);
endmodule : ncps_host_properties
bind ncps_host ncps_host_properties i_ncps_host_properties (.hclk, .hresetn, .ce_n, .cle, .ale, .we_n, .re_n,
  .wp_n, .io_out, .io_oe_n, .ready_busy_pin);
`default_nettype wire

//--- ncps_die_model.sv
/*
  Behavioural die: cache program timing and status bytes.
  Assumes it is clocked by the bench clock; fail comes from the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module ncps_die_model (
  // Bench clock
  input wire logic hclk,
  // Strobed bus
  input wire logic cle,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] io_out,
  // Per-district fail, answers
  input wire logic [1:0] fail,
  output logic [7:0] io_in,
  output logic ready_busy_pin
);
  logic we_q = 1'h1;
  logic [7:0] cmd = 8'h0;
  logic [1:0] cur = 2'h0;
  logic [1:0] prv = 2'h0;
  int dc = 0;
  int pb = 0;
  wire [7:0] sb = (cmd == 8'h71) ? {wp_n, dc == 0, pb == 0, prv, cur, |cur}
    : {wp_n, dc == 0, pb == 0, 3'h0, |prv, |cur};
  // Released bus shows the inverse, not a stale byte
  assign io_in = re_n ? ~sb : sb;
  assign ready_busy_pin = (dc == 0) && (cmd != 8'h10 || pb == 0);
  always @(posedge hclk) begin
    we_q <= we_n;
    if (dc > 0) dc <= dc - 1;
    if (pb > 0) pb <= pb - 1;
    if (cle && we_n && !we_q) begin
      cmd <= io_out;
      if (io_out == 8'h11) dc <= 15;
      if (io_out == 8'h15 || io_out == 8'h10) begin
        dc <= pb + 20;
        pb <= pb + 80;
        cur <= fail;
        prv <= cur;
      end
    end
  end
endmodule : ncps_die_model
`default_nettype wire

//--- test_ncps_host.sv
/*
  Self-checking bench for ncps_host against a die model.
  Assumes the register map of ncps_pkg and AHB-Lite single words.
*/
`timescale 1ns/10ps
`default_nettype none
module test_ncps_host;
  logic hclk = 0;
  logic hresetn = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [31:0] hwdata = 0;
  logic [1:0] fail = 0;
  wire hreadyout, hresp, ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n, ready_busy_pin;
  wire [31:0] hrdata;
  wire [7:0] io_out, io_in;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  integer seed = 32'ha3b3;
  logic [1:0] fq[$];
  logic [31:0] rd;
  initial forever #4 hclk = ~hclk;
  ncps_host i_ncps_host (.hclk, .hresetn, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .io_out, .io_oe_n,
    .io_in, .ready_busy_pin);
  ncps_die_model i_ncps_die_model (.hclk, .cle, .we_n, .re_n, .wp_n, .io_out, .fail, .io_in, .ready_busy_pin);
  // ==========
  // Tasks
  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Entered just after a rising edge; ready and read data are taken at rising edges
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : bus
  task automatic settle();
    do bus(1'h0, ncps_pkg::REG_STATUS, 32'h0); while (rd[ncps_pkg::ST_BUSY] !== 1'h0);
  endtask : settle
  task automatic refuse(input logic [7:0] a, input logic [16:0] v, input logic [7:0] c);
    bus(1'h1, a, 32'(v));
    bus(1'h1, ncps_pkg::REG_CTRL, 32'(c));
    bus(1'h0, ncps_pkg::REG_STATUS, 32'h0);
    cmp(32'(rd[ncps_pkg::ST_ERR]), 32'h1);
    bus(1'h1, ncps_pkg::REG_CTRL, 32'h80);
  endtask : refuse
  task automatic page(input logic [16:0] ra, input logic [16:0] rb, input logic [7:0] c, input logic [7:0] op,
    input logic m);
    logic [1:0] cur;
    logic [1:0] prv;
    logic [7:0] ex;
    bus(1'h1, ncps_pkg::REG_ROW_A, 32'(ra));
    bus(1'h1, ncps_pkg::REG_CTRL, 32'(c));
    settle();
    bus(1'h1, ncps_pkg::REG_DATA, 32'($random(seed)));
    if (m) begin
      if (c[5]) refuse(ncps_pkg::REG_ROW_B, ra, 8'h2);
      if (c[5]) refuse(ncps_pkg::REG_ROW_B, rb ^ 17'h1, 8'h2);
      bus(1'h1, ncps_pkg::REG_ROW_B, 32'(rb));
      bus(1'h1, ncps_pkg::REG_CTRL, 32'h2);
      settle();
      bus(1'h1, ncps_pkg::REG_DATA, 32'($random(seed)));
    end
    cur = 2'($random(seed));
    fail <= cur;
    fq.push_back(cur);
    prv = (fq.size() > 1) ? fq[fq.size() - 2] : 2'h0;
    bus(1'h1, ncps_pkg::REG_CTRL, 32'(op));
    settle();
    ex = m ? {1'h1, 1'h1, op[3], prv, cur, |cur} : {1'h1, 1'h1, op[3], 3'h0, |prv, |cur};
    cmp(32'(rd[7:0]), 32'(ex));
    // Later reads before the next 80h repeat both results once the page buffer is ready
    if (!op[3]) begin
      do begin
        bus(1'h1, ncps_pkg::REG_CTRL, 32'h10);
        settle();
      end while (rd[ncps_pkg::SB_PB_READY] !== 1'h1);
      cmp(32'(rd[7:0]), 32'(ex | 8'h20));
    end
  endtask : page
  // ==========
  // Sequence
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    logic [16:0] r;
    logic [10:0] blk;
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h0, 8'h3c, 32'h0);
    cmp(rd, 32'h0);
    blk = 11'($random(seed));
    for (int p = 0; p < 4; p++) begin
      r = {blk, 6'(p)};
      if (p == 1) refuse(ncps_pkg::REG_ROW_A, r ^ 17'h80, 8'h1);
      page(r, 17'h0, 8'h1, (p == 3) ? 8'h8 : 8'h4, 1'h0);
    end
    for (int p = 0; p < 64; p++) begin
      r = {blk, 6'(p)};
      page(r, r ^ 17'h1c0, (p == 0) ? 8'h21 : 8'h1, (p == 63) ? 8'h8 : 8'h4, 1'h1);
    end
    wrap_up();
  end
endmodule : test_ncps_host
`default_nettype wire
